// ---- logic/clk_select_defines.vh ----
// register offsets, field positions, reset values and timing counts for the clock source select
// assumes a 32-bit AXI4-Lite register bus and a 200 MHz aclk
`ifndef CLK_SELECT_DEFINES_VH
`define CLK_SELECT_DEFINES_VH

`define ADDR_MAIN_CLOCK_MODE   8'h00
`define ADDR_CLOCK_OP_MODE     8'h04
`define ADDR_MAIN_OSC_CONTROL  8'h08
`define ADDR_INTERNAL_OSC_MODE 8'h0c
`define ADDR_OSC_STAB_COUNTER  8'h10

`define BIT_PERIPH_SOURCE_SEL  2
`define BIT_CPU_CLOCK_STATUS   1
`define BIT_MAIN_CLOCK_SEL     0
`define BIT_EXT_CLOCK_ENABLE   7
`define BIT_OSC_SELECT         6
`define BIT_HIGH_FREQ_AMP      0
`define BIT_MAIN_OSC_STOP      7
`define BIT_INT_OSC_STABLE     7
`define BIT_INT_OSC_STOP       0

`define RST_MAIN_OSC_STOP      1'b1

`define CLK_PERIOD_NS          5
`define RESET_PROC_NS          11000
`define RESET_PROC_CYC         ((`RESET_PROC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INT_OSC_STABLE_CYC     16
`define SWITCH_HOLD_EDGES      2

`define RESP_OKAY              2'b00
`define RESP_SLVERR            2'b10

`endif

// ---- logic/glitchless_clock_mux.v ----
// glitch-free two-way clock switch on sampled clock levels
// assumes both sources are sampled levels synchronous to aclk and the old source keeps toggling
`timescale 1ns/10ps
`include "clk_select_defines.vh"

module glitchless_clock_mux #(
   parameter HOLD_EDGES = `SWITCH_HOLD_EDGES
) (
   input  wire aclk,       // system clock
   input  wire aresetn,    // synchronous reset, active low
   input  wire src0,       // source chosen when sel is 0
   input  wire src1,       // source chosen when sel is 1
   input  wire sel,        // requested source
   output reg  clk_out,    // switched clock level
   output reg  sel_active  // source actually driving clk_out
);

   localparam RUN   = 2'd0;
   localparam DRAIN = 2'd1;
   localparam PARK  = 2'd2;

   reg [1:0] state_reg;
   reg [7:0] edge_cnt_reg;
   reg       old_q_reg;
   wire      old_src = sel_active ? src1 : src0;
   wire      new_src = sel_active ? src0 : src1;
   wire      old_fall = old_q_reg & ~old_src;

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg    <= RUN;
         edge_cnt_reg <= 8'h00;
         old_q_reg    <= 1'b0;
         clk_out      <= 1'b0;
         sel_active   <= 1'b0;
      end else begin
         old_q_reg <= old_src;
         case (state_reg)
            RUN: begin
               clk_out <= old_src;
               edge_cnt_reg <= 8'h00;
               if (sel != sel_active)
                  state_reg <= DRAIN;
            end
            DRAIN: begin
               // keep running on the old clock for a few of its cycles
               clk_out <= old_src;
               if (old_fall) begin
                  edge_cnt_reg <= edge_cnt_reg + 8'h01;
                  if (edge_cnt_reg == HOLD_EDGES[7:0] - 8'h01) begin
                     clk_out   <= 1'b0; // stop only with the old clock low
                     state_reg <= PARK;
                  end
               end
            end
            PARK: begin
               clk_out <= 1'b0;
               if (!new_src) begin
                  // hand over while the new clock is low, so its first pulse is whole
                  sel_active <= ~sel_active; // status follows the finished switch
                  state_reg  <= RUN;
               end
            end
            default: state_reg <= RUN;
         endcase
      end
   end

endmodule // glitchless_clock_mux

// ---- logic/clock_source_select.v ----
// clock source selection with AXI4-Lite registers, power-on sequencing and glitch-free switching
// assumes oscillator waveforms arrive as levels sampled synchronously on aclk
//
// Notes on behaviour
// - source/main select route internal or high-speed clock
// - external enable picks pin, else crystal
// - peripheral select bit 2, main select bit 0
// - ext enable 7, osc select 6, amplifier 0
// - main oscillator stop at bit 7
// - internal stable flag 7, stop bit 0
// - CPU runs internal clock after reset
// - threshold crossing, reset processing, then run
// - amplifier and peripheral select write once
// - bit 1 reports clock actually running CPU
// - old clock runs several cycles after change
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "clk_select_defines.vh"

module clock_source_select #(
   parameter RESET_PROC_CYCLES = `RESET_PROC_CYC,     // reset processing length
   parameter STABLE_CYCLES     = `INT_OSC_STABLE_CYC, // internal oscillator settle time
   parameter HOLD_EDGES        = `SWITCH_HOLD_EDGES   // old-clock cycles kept after a change
) (
   input  wire        aclk,                     // system clock, 200 MHz
   input  wire        aresetn,                  // synchronous reset, active low
   input  wire        s_axi_awvalid,            // write address valid
   output reg         s_axi_awready,            // write address ready
   input  wire [7:0]  s_axi_awaddr,             // write address
   input  wire        s_axi_wvalid,             // write data valid
   output reg         s_axi_wready,             // write data ready
   input  wire [31:0] s_axi_wdata,              // write data
   input  wire [3:0]  s_axi_wstrb,              // write byte strobes
   output reg         s_axi_bvalid,             // write response valid
   input  wire        s_axi_bready,             // write response ready
   output reg  [1:0]  s_axi_bresp,              // write response
   input  wire        s_axi_arvalid,            // read address valid
   output reg         s_axi_arready,            // read address ready
   input  wire [7:0]  s_axi_araddr,             // read address
   output reg         s_axi_rvalid,             // read data valid
   input  wire        s_axi_rready,             // read data ready
   output reg  [31:0] s_axi_rdata,              // read data
   output reg  [1:0]  s_axi_rresp,              // read response
   input  wire        power_on_clear_threshold, // 1 selects the higher supply threshold
   input  wire        supply_above_high,        // supply above the higher threshold
   input  wire        supply_above_low,         // supply above the lower threshold
   input  wire        internal_osc_clk,         // internal high-speed oscillator level
   input  wire        crystal_osc_clk,          // crystal oscillator level
   input  wire        external_clk_pin,         // external clock input pin level
   output wire        cpu_clk,                  // clock to the CPU (flop output of mux)
   output wire        periph_clk,               // clock to peripherals (flop output of mux)
   output reg         run_state,                // reset processing done, clocks running
   output reg         high_freq_amp_out,        // amplifier gain control to the crystal
   output reg         main_osc_enable           // high-speed source enabled
);

   localparam POWER_WAIT = 2'd0;
   localparam RESET_PROC = 2'd1;
   localparam RUNNING    = 2'd2;

   reg [1:0]  pwr_state_reg;
   reg [11:0] reset_cnt_reg;
   reg        periph_source_select;
   reg        main_clock_select;
   reg        external_clock_enable;
   reg        oscillator_select;
   reg        high_freq_amplifier;
   reg        main_osc_stop;
   reg        internal_osc_stop;
   reg        internal_osc_stable_flag;
   reg [7:0]  stable_cnt_reg;
   reg [7:0]  osc_stabilization_counter;
   reg        hs_q_reg;
   reg        mode_lock_reg;
   reg        amp_lock_reg;
   reg        aw_full_reg;
   reg        w_full_reg;
   reg [7:0]  aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0]  w_strb_reg;
   reg [31:0] rdata_next;
   reg        rmapped_next;
   wire       cpu_clock_status;
   wire       periph_active;
   wire       supply_ok = power_on_clear_threshold ? supply_above_high : supply_above_low;
   wire       do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
   wire       wr_lane0 = do_write & w_strb_reg[0];
   wire       hs_enabled = oscillator_select & ~main_osc_stop;
   wire       hs_raw = external_clock_enable ? external_clk_pin : crystal_osc_clk;
   wire       hs_clk = hs_raw & hs_enabled;
   reg        ihs_gate_reg;
   wire       ihs_clk = internal_osc_clk & ihs_gate_reg;
   wire       cpu_sel = periph_source_select & main_clock_select;
   wire       wr_mapped = (aw_addr_reg == `ADDR_MAIN_CLOCK_MODE) |
                          (aw_addr_reg == `ADDR_CLOCK_OP_MODE) |
                          (aw_addr_reg == `ADDR_MAIN_OSC_CONTROL) |
                          (aw_addr_reg == `ADDR_INTERNAL_OSC_MODE) |
                          (aw_addr_reg == `ADDR_OSC_STAB_COUNTER);

   // power-on sequencing: threshold, reset processing, then internal clock run
   always @(posedge aclk) begin
      if (!aresetn) begin
         pwr_state_reg <= POWER_WAIT;
         reset_cnt_reg <= 12'h000;
         run_state     <= 1'b0;
      end else begin
         case (pwr_state_reg)
            POWER_WAIT: begin
               reset_cnt_reg <= 12'h000;
               if (supply_ok)
                  pwr_state_reg <= RESET_PROC;
            end
            RESET_PROC: begin
               reset_cnt_reg <= reset_cnt_reg + 12'h001;
               if (reset_cnt_reg == RESET_PROC_CYCLES[11:0] - 12'h001) begin
                  pwr_state_reg <= RUNNING;
                  run_state     <= 1'b1;
               end
            end
            RUNNING: run_state <= 1'b1;
            default: pwr_state_reg <= POWER_WAIT;
         endcase
      end
   end

   // control registers; reset leaves the CPU on the internal oscillator
   always @(posedge aclk) begin
      if (!aresetn) begin
         periph_source_select  <= 1'b0;
         main_clock_select     <= 1'b0;
         external_clock_enable <= 1'b0;
         oscillator_select     <= 1'b0;
         high_freq_amplifier   <= 1'b0;
         main_osc_stop         <= `RST_MAIN_OSC_STOP;
         internal_osc_stop     <= 1'b0;
         mode_lock_reg         <= 1'b0;
         amp_lock_reg          <= 1'b0;
      end else if (wr_lane0) begin
         case (aw_addr_reg)
            `ADDR_MAIN_CLOCK_MODE: begin
               main_clock_select <= w_data_reg[`BIT_MAIN_CLOCK_SEL];
               mode_lock_reg     <= 1'b1;
               if (!mode_lock_reg)
                  periph_source_select <= w_data_reg[`BIT_PERIPH_SOURCE_SEL];
            end
            `ADDR_CLOCK_OP_MODE: begin
               external_clock_enable <= w_data_reg[`BIT_EXT_CLOCK_ENABLE];
               oscillator_select     <= w_data_reg[`BIT_OSC_SELECT];
               amp_lock_reg          <= 1'b1;
               if (!amp_lock_reg)
                  high_freq_amplifier <= w_data_reg[`BIT_HIGH_FREQ_AMP];
            end
            `ADDR_MAIN_OSC_CONTROL: main_osc_stop <= w_data_reg[`BIT_MAIN_OSC_STOP];
            `ADDR_INTERNAL_OSC_MODE: internal_osc_stop <= w_data_reg[`BIT_INT_OSC_STOP];
            default: ;
         endcase
      end
   end

   // oscillator status: internal settle flag and high-speed stabilization count
   always @(posedge aclk) begin
      if (!aresetn) begin
         stable_cnt_reg            <= 8'h00;
         internal_osc_stable_flag  <= 1'b0;
         osc_stabilization_counter <= 8'h00;
         hs_q_reg                  <= 1'b0;
         high_freq_amp_out         <= 1'b0;
         main_osc_enable           <= 1'b0;
         ihs_gate_reg              <= 1'b0;
      end else begin
         hs_q_reg          <= hs_clk;
         high_freq_amp_out <= high_freq_amplifier;
         main_osc_enable   <= hs_enabled;
         if (!internal_osc_clk) ihs_gate_reg <= ~internal_osc_stop & run_state;
         if (internal_osc_stop || !run_state) begin
            stable_cnt_reg           <= 8'h00;
            internal_osc_stable_flag <= 1'b0;
         end else if (stable_cnt_reg == STABLE_CYCLES[7:0] - 8'h01) begin
            internal_osc_stable_flag <= 1'b1;
         end else begin
            stable_cnt_reg <= stable_cnt_reg + 8'h01;
         end
         if (!hs_enabled)
            osc_stabilization_counter <= 8'h00;
         else if (hs_clk && !hs_q_reg && osc_stabilization_counter != 8'hff)
            osc_stabilization_counter <= osc_stabilization_counter + 8'h01;
      end
   end

   glitchless_clock_mux #(.HOLD_EDGES(HOLD_EDGES)) cpu_mux (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .src0       (ihs_clk),
      .src1       (hs_clk),
      .sel        (cpu_sel),
      .clk_out    (cpu_clk),
      .sel_active (cpu_clock_status)
   );

   glitchless_clock_mux #(.HOLD_EDGES(HOLD_EDGES)) periph_mux (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .src0       (ihs_clk),
      .src1       (hs_clk),
      .sel        (periph_source_select),
      .clk_out    (periph_clk),
      .sel_active (periph_active)
   );

   // write channel: address and data taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg   <= 1'b0;
         w_full_reg    <= 1'b0;
         aw_addr_reg   <= 8'h00;
         w_data_reg    <= 32'h00000000;
         w_strb_reg    <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_full_reg & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
         s_axi_wready  <= ~w_full_reg & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always @* begin
      rdata_next   = 32'h00000000;
      rmapped_next = 1'b1;
      case (s_axi_araddr)
         `ADDR_MAIN_CLOCK_MODE: begin
            rdata_next[`BIT_PERIPH_SOURCE_SEL] = periph_source_select;
            rdata_next[`BIT_CPU_CLOCK_STATUS]  = cpu_clock_status;
            rdata_next[`BIT_MAIN_CLOCK_SEL]    = main_clock_select;
         end
         `ADDR_CLOCK_OP_MODE: begin
            rdata_next[`BIT_EXT_CLOCK_ENABLE] = external_clock_enable;
            rdata_next[`BIT_OSC_SELECT]       = oscillator_select;
            rdata_next[`BIT_HIGH_FREQ_AMP]    = high_freq_amplifier;
         end
         `ADDR_MAIN_OSC_CONTROL: rdata_next[`BIT_MAIN_OSC_STOP] = main_osc_stop;
         `ADDR_INTERNAL_OSC_MODE: begin
            rdata_next[`BIT_INT_OSC_STABLE] = internal_osc_stable_flag;
            rdata_next[`BIT_INT_OSC_STOP]   = internal_osc_stop;
         end
         `ADDR_OSC_STAB_COUNTER: rdata_next[7:0] = osc_stabilization_counter;
         default: rmapped_next = 1'b0;
      endcase
   end

   // read channel: one cycle from address accept to data
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdata_next;
            s_axi_rresp  <= rmapped_next ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // clock_source_select

// ---- tb/clk_sel_checker.sv ----
// checker for the clock source select: bus handshakes, run sequencing, clean clocks
// assumes it is bound to clock_source_select and sees only its ports
`timescale 1ns/10ps
module clk_sel_checker #(
   parameter RESET_PROC_CYCLES = 8
) (
   input wire aclk,                     // clock
   input wire aresetn,                  // reset, active low
   input wire s_axi_awvalid,            // write address valid
   input wire s_axi_awready,            // write address ready
   input wire s_axi_bvalid,             // write response valid
   input wire s_axi_bready,             // write response ready
   input wire s_axi_arvalid,            // read address valid
   input wire s_axi_arready,            // read address ready
   input wire s_axi_rvalid,             // read data valid
   input wire s_axi_rready,             // read data ready
   input wire power_on_clear_threshold, // threshold choice
   input wire supply_above_high,        // supply comparator
   input wire supply_above_low,         // supply comparator
   input wire run_state,                // clocks running
   input wire cpu_clk,                  // cpu clock
   input wire periph_clk,               // peripheral clock
   input wire high_freq_amp_out         // amplifier control
);
   reg  [15:0] sup_cnt;
   reg         amp_moved;
   wire        supply_ok = power_on_clear_threshold ? supply_above_high : supply_above_low;
   // cycles with the chosen supply comparator high since reset release
   always @(posedge aclk) begin
      if (!aresetn) begin
         sup_cnt   <= 16'h0000;
         amp_moved <= 1'b0;
      end else begin
         if (supply_ok && sup_cnt != 16'hffff) sup_cnt <= sup_cnt + 16'h0001;
         if (high_freq_amp_out) amp_moved <= 1'b1;
      end
   end
   a_aw_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_awready |=> !s_axi_awready) else $error("awready longer than one cycle");
   a_aw_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_awvalid && !s_axi_awready && !s_axi_bvalid |=> s_axi_awready)
      else $error("write address not taken next cycle");
   a_ar_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data after ar");
   a_b_drop: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid after handshake");
   a_r_drop: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid after handshake");
   a_run_delay: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(run_state) |-> sup_cnt >= RESET_PROC_CYCLES - 1) else $error("run state too early");
   a_cpu_prerun: assert property (@(posedge aclk) disable iff (!aresetn)
      !run_state |-> !cpu_clk) else $error("cpu clock before run state");
   a_cpu_clean: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(cpu_clk) |=> $stable(cpu_clk)) else $error("short pulse on cpu clock");
   a_periph_clean: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(periph_clk) |=> $stable(periph_clk)) else $error("short pulse on periph clock");
   a_amp_once: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(high_freq_amp_out) |-> !amp_moved) else $error("amplifier changed twice");
endmodule // clk_sel_checker

bind clock_source_select clk_sel_checker #(.RESET_PROC_CYCLES(RESET_PROC_CYCLES)) chk (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .power_on_clear_threshold,
   .supply_above_high, .supply_above_low, .run_state, .cpu_clk, .periph_clk,
   .high_freq_amp_out);

// ---- tb/osc_source_model.sv ----
// oscillator sources: free internal oscillator, gated crystal, free external pin
// assumes levels are sampled on aclk, each half period two or more cycles
`timescale 1ns/10ps
module osc_source_model #(
   parameter IH = 5, // internal half period, cycles
   parameter XH = 3, // crystal half period
   parameter EH = 2  // external half period
) (
   input  wire  aclk,             // clock
   input  wire  main_osc_enable,  // crystal enabled
   output logic internal_osc_clk, // internal level
   output logic crystal_osc_clk,  // crystal level
   output logic external_clk_pin  // external pin level
);
   int ci = 0;
   int cx = 0;
   int ce = 0;
   initial begin
      internal_osc_clk = 1'b0;
      crystal_osc_clk  = 1'b0;
      external_clk_pin = 1'b0;
   end
   always @(posedge aclk) begin
      ci <= (ci == IH - 1) ? 0 : ci + 1;
      ce <= (ce == EH - 1) ? 0 : ce + 1;
      cx <= (!main_osc_enable || cx == XH - 1) ? 0 : cx + 1;
      if (ci == IH - 1) internal_osc_clk <= ~internal_osc_clk;
      if (ce == EH - 1) external_clk_pin <= ~external_clk_pin;
      // a stopped crystal rests low and gives no edges
      if (!main_osc_enable) crystal_osc_clk <= 1'b0;
      else if (cx == XH - 1) crystal_osc_clk <= ~crystal_osc_clk;
   end
endmodule // osc_source_model

// ---- tb/test_system_clock_source_select.sv ----
// testbench for the clock source select: register bus, power-on, switching, write-once bits
// assumes the oscillator model drives the source levels
`timescale 1ns/10ps
`include "clk_select_defines.vh"
module test_system_clock_source_select;
   localparam IH = 5, XH = 3, EH = 2;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, power_on_clear_threshold, supply_above_high, supply_above_low;
   logic        internal_osc_clk, crystal_osc_clk, external_clk_pin, cpu_clk, periph_clk;
   logic        run_state, high_freq_amp_out, main_osc_enable;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          err_count, cmp_count;

   clock_source_select #(.RESET_PROC_CYCLES(8), .STABLE_CYCLES(4)) uut (
      .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .power_on_clear_threshold, .supply_above_high,
      .supply_above_low, .internal_osc_clk, .crystal_osc_clk, .external_clk_pin, .cpu_clk,
      .periph_clk, .run_state, .high_freq_amp_out, .main_osc_enable);
   osc_source_model #(.IH(IH), .XH(XH), .EH(EH)) osc (
      .aclk, .main_osc_enable, .internal_osc_clk, .crystal_osc_clk, .external_clk_pin);

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task tally_and_finish;
      $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task check(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      bit ad, wd;
      n = 0; ad = 0; wd = 0;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'b1;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
      while (!(ad && wd) && n < 50) begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) begin s_axi_awvalid <= 1'b0; ad = 1; end
         if (s_axi_wready) begin s_axi_wvalid <= 1'b0; wd = 1; end
      end
      do begin @(posedge aclk); n++; end while (!s_axi_bvalid && n < 50);
      if (n >= 50) err_count++;
      s_axi_bready <= 1'b0;
      check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask

   task axi_rd(input logic [7:0] a, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do begin @(posedge aclk); n++; end while (!s_axi_arready && n < 50);
      s_axi_arvalid <= 1'b0;
      do begin @(posedge aclk); n++; end while (!s_axi_rvalid && n < 50);
      if (n >= 50) err_count++;
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      axi_rd(a, er);
      check("rdata", e, rd);
   endtask

   task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      int k;
      k = 0;
      do begin axi_rd(a, `RESP_OKAY); k++; end while ((rd & m) !== v && k < 300);
      check("polled bits", v, rd & m);
   endtask

   // cycles between two rising edges of the cpu (pc 0) or peripheral (pc 1) clock
   task per(input bit pc, input logic [31:0] e);
      int n, r;
      logic q, c, p;
      logic [31:0] len;
      n = 0; r = 0; len = 32'h0;
      repeat (40) @(posedge aclk); // let a pending switch finish first
      q = pc ? periph_clk : cpu_clk;
      while (r < 2 && n < 100) begin
         @(posedge aclk);
         n++;
         c = pc ? periph_clk : cpu_clk;
         if (c && !q) begin if (r == 1) len = n; r++; n = 0; end
         q = c;
      end
      check(pc ? "periph period" : "cpu period", e, len);
   endtask

   task wait_run;
      int k;
      k = 0;
      while (!run_state && k < 60) begin @(posedge aclk); k++; end
      check("run_state", 32'h1, {31'h0, run_state});
   endtask

   task t_power_on;
      repeat (12) @(posedge aclk);
      check("run_state", 32'h0, {31'h0, run_state});
      supply_above_high <= 1'b1;
      wait_run();
      rd_chk(8'h00, 32'h0, `RESP_OKAY);
      rd_chk(8'h04, 32'h0, `RESP_OKAY);
      rd_chk(8'h08, 32'h80, `RESP_OKAY);
      rd_chk(8'h14, 32'h0, `RESP_SLVERR);
      axi_wr(8'h14, 32'hff, `RESP_SLVERR);
      per(0, 2 * IH);
      per(1, 2 * IH);
      poll(8'h0c, 32'h81, 32'h80);
      $display("test power_on done");
   endtask

   task t_crystal;
      axi_wr(8'h04, 32'h40, `RESP_OKAY);
      axi_wr(8'h08, 32'h00, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      check("main_osc_enable", 32'h1, {31'h0, main_osc_enable});
      poll(8'h10, 32'h80, 32'h80);
      axi_wr(8'h00, 32'h04, `RESP_OKAY);
      per(1, 2 * XH);
      per(0, 2 * IH);
      axi_wr(8'h00, 32'h05, `RESP_OKAY);
      rd_chk(8'h00, 32'h05, `RESP_OKAY);
      poll(8'h00, 32'h02, 32'h02);
      per(0, 2 * XH);
      axi_wr(8'h00, 32'h01, `RESP_OKAY);
      rd_chk(8'h00, 32'h07, `RESP_OKAY);
      $display("test crystal done");
   endtask

   task t_return;
      axi_wr(8'h0c, 32'h00, `RESP_OKAY);
      poll(8'h0c, 32'h80, 32'h80);
      axi_wr(8'h00, 32'h04, `RESP_OKAY);
      poll(8'h00, 32'h02, 32'h00);
      rd_chk(8'h00, 32'h04, `RESP_OKAY);
      per(0, 2 * IH);
      axi_wr(8'h04, 32'h41, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      check("amp", 32'h0, {31'h0, high_freq_amp_out});
      per(1, 2 * XH);
      $display("test return done");
   endtask

   task t_amp_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      wait_run();
      axi_wr(8'h04, 32'h81, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      check("amp", 32'h1, {31'h0, high_freq_amp_out});
      axi_wr(8'h04, 32'hc0, `RESP_OKAY);
      rd_chk(8'h04, 32'hc1, `RESP_OKAY);
      axi_wr(8'h08, 32'h00, `RESP_OKAY);
      axi_wr(8'h00, 32'h04, `RESP_OKAY);
      per(1, 2 * EH);
      per(0, 2 * IH);
      $display("test amp_reset done");
   endtask

   initial begin
      err_count = 0; cmp_count = 0; aresetn = 1'b0;
      s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0; s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf; power_on_clear_threshold = 1'b1;
      supply_above_high = 1'b0; supply_above_low = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_power_on();
      t_crystal();
      t_return();
      t_amp_reset();
      tally_and_finish();
   end

   initial begin
      repeat (30000) @(posedge aclk);
      err_count++;
      tally_and_finish();
   end
endmodule // test_system_clock_source_select
